// *** design/smd_dma_master.sv ***
// shared memory dma master: arbitration, memory cycles and message buffer
`timescale 1ns/1ps
`default_nettype none
module smd_dma_master #(
   parameter int BUF_DEPTH = smd_pkg::BUF_WORDS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [smd_pkg::DATA_W-1:0] control_word,
   input wire logic job_valid,
   input wire smd_pkg::smd_job_type job,
   output logic job_ready,
   input wire logic [smd_pkg::DATA_W-1:0] core_wdata,
   input wire logic core_wvalid,
   output logic core_wready,
   output logic [smd_pkg::DATA_W-1:0] core_rdata,
   output logic core_rvalid,
   output logic job_done,
   output logic memory_bus_request,
   input wire logic memory_bus_grant,
   output logic memory_bus_owned,
   input wire logic transfer_acknowledge_n,
   input wire logic [smd_pkg::DATA_W-1:0] mem_data_in,
   output smd_pkg::smd_mem_out_type mem_out
);
   import smd_pkg::*;

   typedef enum {ST_IDLE, ST_FILL, ST_REQ, ST_OWN, ST_ACC, ST_WAIT, ST_END, ST_GAP, ST_DRAIN,
                 ST_REL} smd_state_type;

   smd_state_type state_q;
   logic grant_s;
   logic ack_n_s;
   logic [DATA_W-1:0] buf_q [BUF_DEPTH];
   logic buffered_q;
   logic write_q;
   logic [ADDR_W-1:0] addr_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] fill_q;
   logic [CNT_W-1:0] mem_idx_q;
   logic [DATA_W-1:0] rd_latch_q;
   logic last_word;
   logic [CNT_W-1:0] drain_idx_q;
   logic rel_go;
   logic wheld_q;

   smd_sync3 #(.RESET_VAL(1'b0)) u_grant_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(memory_bus_grant),
      .dout(grant_s)
   );
   smd_sync3 #(.RESET_VAL(1'b1)) u_ack_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(transfer_acknowledge_n),
      .dout(ack_n_s)
   );

   // in per-word mode every word is its own ownership
   assign last_word = !buffered_q || (mem_idx_q == count_q - 6'h01);
   // synchronised grant and acknowledge lag their pins; stale highs or lows must clear first
   assign rel_go = !grant_s && ack_n_s;

   // state sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (job_valid && job_ready) begin
                  // buffered writes collect all words first so the burst never starves
                  if (control_word[BUF_EN_BIT] && job.count > 6'h01 && job.write) begin // [R12] [R13]
                     state_q <= ST_FILL;
                  end else begin
                     state_q <= ST_REQ;
                  end
               end
            end
            ST_FILL: begin
               if (core_wvalid && fill_q == count_q - 6'h01) begin
                  state_q <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (grant_s && (buffered_q || !write_q || wheld_q)) begin // [R1] [R2]
                  state_q <= ST_OWN;
               end
            end
            ST_OWN: state_q <= ST_ACC; // [R4] address before strobes
            ST_ACC: state_q <= ST_WAIT; // [R6]
            ST_WAIT: begin
               if (!ack_n_s) begin // [R8] [R9] [R11]
                  state_q <= ST_END; // [R10]
               end
            end
            ST_END: begin
               if (last_word) begin
                  state_q <= ST_REL; // [R3]
               end else begin
                  state_q <= ST_GAP; // [R13] [R14] stay owned
               end
            end
            // an old acknowledge low must clear before the next access may start
            ST_GAP: begin
               if (ack_n_s) begin
                  state_q <= ST_ACC; // [R9]
               end
            end
            ST_REL: begin
               if (!rel_go) begin
                  state_q <= ST_REL; // [R15] fresh grant needed for the next word
               end else if (buffered_q && !write_q) begin
                  state_q <= ST_DRAIN;
               end else if (!buffered_q && mem_idx_q != count_q) begin
                  state_q <= ST_REQ; // [R15] rearbitrate per word
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_DRAIN: begin
               if (drain_idx_q == count_q - 6'h01) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // job capture; count clipped to the burst limit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buffered_q <= 1'b0;
         write_q <= 1'b0;
         count_q <= '0;
      end else if (state_q == ST_IDLE && job_valid) begin
         buffered_q <= control_word[BUF_EN_BIT] && job.count > 6'h01; // [R12] [R17]
         write_q <= job.write;
         if (job.count > MAX_BURST) begin
            count_q <= MAX_BURST; // [R17]
         end else if (job.count == 6'h00) begin
            count_q <= 6'h01;
         end else begin
            count_q <= job.count;
         end
      end
   end

   // address and word index
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= '0;
         mem_idx_q <= '0;
      end else if (state_q == ST_IDLE && job_valid) begin
         addr_q <= job.addr;
         mem_idx_q <= '0;
      end else if (state_q == ST_END) begin
         addr_q <= addr_q + 16'h0001;
         mem_idx_q <= mem_idx_q + 6'h01;
      end
   end

   // internal buffer: no external port reaches it, only this sequencer
   always_ff @(posedge clk) begin // [R16]
      if (state_q == ST_FILL && core_wvalid) begin
         buf_q[fill_q[4:0]] <= core_wdata;
      end else if (state_q == ST_REQ && !buffered_q && write_q && core_wvalid && core_wready) begin
         buf_q[0] <= core_wdata;
      end else if (state_q == ST_WAIT && !ack_n_s && !write_q && buffered_q) begin
         buf_q[mem_idx_q[4:0]] <= mem_data_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_q <= '0;
      end else if (state_q == ST_IDLE) begin
         fill_q <= '0;
      end else if (state_q == ST_FILL && core_wvalid) begin
         fill_q <= fill_q + 6'h01;
      end
   end

   // per-word write: the word is held once handed over, so later words cannot overwrite it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wheld_q <= 1'b0;
      end else if (state_q != ST_REQ) begin
         wheld_q <= 1'b0;
      end else if (core_wvalid && core_wready) begin
         wheld_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_latch_q <= '0;
      end else if (state_q == ST_WAIT && !ack_n_s) begin
         rd_latch_q <= mem_data_in;
      end
   end

   // handshakes to the protocol core
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         job_ready <= 1'b0;
         core_wready <= 1'b0;
      end else begin
         job_ready <= (state_q == ST_IDLE) && !(job_valid && job_ready);
         core_wready <= (state_q == ST_IDLE && job_valid && job_ready && job.write)
            || (state_q == ST_FILL && !(core_wvalid && fill_q == count_q - 6'h01))
            || (state_q == ST_REQ && !buffered_q && write_q && !wheld_q
               && !(core_wvalid && core_wready))
            || (state_q == ST_REL && rel_go && !buffered_q && write_q
               && mem_idx_q != count_q);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drain_idx_q <= '0;
      end else if (state_q == ST_DRAIN) begin
         drain_idx_q <= drain_idx_q + 6'h01;
      end else begin
         drain_idx_q <= '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_rdata <= '0;
         core_rvalid <= 1'b0;
         job_done <= 1'b0;
      end else begin
         core_rvalid <= 1'b0;
         job_done <= 1'b0;
         if (state_q == ST_DRAIN) begin
            core_rdata <= buf_q[drain_idx_q[4:0]];
            core_rvalid <= 1'b1;
            job_done <= drain_idx_q == count_q - 6'h01;
         end else if (state_q == ST_END && !write_q && !buffered_q) begin
            core_rdata <= rd_latch_q;
            core_rvalid <= 1'b1;
         end
         if (state_q == ST_REL && rel_go && !(buffered_q && !write_q)
             && (buffered_q || mem_idx_q == count_q)) begin
            job_done <= 1'b1;
         end
      end
   end

   // arbitration pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         memory_bus_request <= 1'b0;
         memory_bus_owned <= 1'b0;
      end else begin
         memory_bus_request <= state_q == ST_REQ && !grant_s; // [R1]
         memory_bus_owned <= state_q inside {ST_OWN, ST_ACC, ST_WAIT, ST_GAP}
            || (state_q == ST_END && !last_word)
            || (state_q == ST_REQ && grant_s && (buffered_q || !write_q || wheld_q)); // [R2] [R3]
      end
   end

   // memory pins: released whenever the bus is not ours
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_out <= '{addr: '0, addr_oe: 1'b0, data_out: '0, data_oe: 1'b0,
                      chip_select_n: 1'b1, read_enable_n: 1'b1, write_strobe_n: 1'b1,
                      strobe_oe: 1'b0}; // [R22]
      end else begin
         mem_out.addr <= addr_q;
         mem_out.addr_oe <= state_q inside {ST_OWN, ST_ACC, ST_WAIT, ST_GAP}
            || (state_q == ST_END && !last_word); // [R4] [R22]
         mem_out.strobe_oe <= state_q inside {ST_OWN, ST_ACC, ST_WAIT, ST_GAP}
            || (state_q == ST_END && !last_word); // [R22]
         mem_out.data_out <= buffered_q ? buf_q[mem_idx_q[4:0]] : buf_q[0];
         mem_out.data_oe <= write_q && (state_q inside {ST_OWN, ST_ACC, ST_WAIT, ST_GAP}
            || (state_q == ST_END && !last_word)); // [R5]
         // zero-wait: strobes span access plus every wait cycle until the synchronised acknowledge is low, longer than the two cycles of [R7]
         mem_out.chip_select_n <= !(state_q == ST_ACC
            || (state_q == ST_WAIT && ack_n_s)); // [R6]
         mem_out.read_enable_n <= !(!write_q && (state_q == ST_ACC
            || (state_q == ST_WAIT && ack_n_s))); // [R6]
         mem_out.write_strobe_n <= !(write_q && (state_q == ST_ACC
            || (state_q == ST_WAIT && ack_n_s))); // [R6]
      end
   end
endmodule
`default_nettype wire

// *** design/smd_pkg.sv ***
// package: constants and carrier types for the shared memory dma master
// Function
// R1: request memory bus and wait for grant before touching it
// R2: on grant, assert bus-owned output to claim the memory bus
// R3: hold bus-owned across all accesses; drop only after the last one
// R4: drive the sixteen-bit address once the bus is owned
// R5: drive data only on writes; leave data as input on reads
// R6: assert select, read-enable, write strobes after address is active
// R7: zero-wait access completes in two clock cycles; here the three-stage acknowledge synchroniser makes it take longer
// R8: sample active-low transfer acknowledge each rising edge during a cycle
// R9: acknowledge negated extends the cycle one clock, sampling again
// R10: acknowledge seen asserted ends the cycle one clock later
// R11: slow memory keeps acknowledge high until it can finish
// R12: buffer used only while control bit 6 is set
// R13: buffered receive data written in one burst under one ownership
// R14: buffered transmit data fetched in one burst, bus kept till done
// R15: unbuffered mode arbitrates separately for each data word
// R16: internal buffer has no host or subsystem port
// R17: buffered burst moves more than one and at most 32 words
// R18: controller writes data plus 2, 6 or 8 record words
// R19: monitor writes data plus 7 or 9 record words
// R20: terminal reads data plus 4 descriptor words
// R21: internal-memory variant keeps buffer bit cleared
// R22: address, data, strobes released while bus not owned
package smd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int BUF_WORDS = 32;
   localparam int CNT_W = 6;
   localparam int BUF_EN_BIT = 6;
   localparam logic [CNT_W-1:0] REC_CTRL_IRQ = 6'h02; // [R18]
   localparam logic [CNT_W-1:0] REC_CTRL_BLK = 6'h06; // [R18]
   localparam logic [CNT_W-1:0] REC_CTRL_ALL = 6'h08; // [R18]
   localparam logic [CNT_W-1:0] REC_MON_BASE = 6'h07; // [R19]
   localparam logic [CNT_W-1:0] REC_MON_IRQ = 6'h09; // [R19]
   localparam logic [CNT_W-1:0] REC_TERM_DESC = 6'h04; // [R20]
   localparam logic [CNT_W-1:0] MAX_BURST = 6'h20;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

   typedef enum logic [1:0] {REC_NONE, REC_IRQ, REC_BLK, REC_ALL} smd_rec_type;

   // one transfer job from the protocol core
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [CNT_W-1:0] count;
   } smd_job_type;

   // memory pins, outputs
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic addr_oe;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
      logic chip_select_n;
      logic read_enable_n;
      logic write_strobe_n;
      logic strobe_oe;
   } smd_mem_out_type;
endpackage

// *** design/smd_sync3.sv ***
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module smd_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // a change counts only once two stages agree, so one glitchy sample is ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= RESET_VAL;
      end else if (s2_q == s3_q) begin
         dout <= s3_q;
      end
   end
endmodule
`default_nettype wire

// *** bench/smd_dma_master_monitor.sv ***
// checker for the shared memory dma master ports
`timescale 1ns/1ps
`default_nettype none
module smd_mon (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [smd_pkg::DATA_W-1:0] control_word,
   input wire logic job_valid,
   input wire smd_pkg::smd_job_type job,
   input wire logic job_ready,
   input wire logic memory_bus_grant,
   input wire logic memory_bus_owned,
   input wire logic transfer_acknowledge_n,
   input wire smd_pkg::smd_mem_out_type mem_out
);
   import smd_pkg::*;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] n_q;
   logic buf_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         buf_q <= 1'b0;
      end else if (job_valid && job_ready) begin
         cnt_q <= job.count;
         buf_q <= control_word[BUF_EN_BIT];
      end
   end
   // accesses per ownership, restarted when the bus is taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) n_q <= '0;
      else if ($rose(memory_bus_owned)) n_q <= '0;
      else if ($fell(mem_out.chip_select_n)) n_q <= n_q + 6'h01;
   end
   a_grant_first: assert property ($rose(memory_bus_owned) |-> memory_bus_grant)
      else $error("bus taken without grant");
   a_release_pins: assert property (!memory_bus_owned |->
      !(mem_out.addr_oe || mem_out.data_oe || mem_out.strobe_oe))
      else $error("pins driven while bus not owned");
   a_strobe_addr: assert property (!mem_out.chip_select_n |->
      mem_out.addr_oe && mem_out.strobe_oe && memory_bus_owned)
      else $error("select without address");
   a_read_undriven: assert property (!mem_out.read_enable_n |-> !mem_out.data_oe)
      else $error("data driven on read");
   a_write_driven: assert property (!mem_out.write_strobe_n |->
      mem_out.data_oe && mem_out.read_enable_n)
      else $error("write without data");
   a_owned_held: assert property ($fell(memory_bus_owned) |->
      mem_out.chip_select_n && $past(mem_out.chip_select_n))
      else $error("bus released mid access");
   a_wait_stretch: assert property (transfer_acknowledge_n [*6] |->
      !$rose(mem_out.chip_select_n))
      else $error("cycle ended without acknowledge");
   a_ack_ends: assert property (!mem_out.chip_select_n && !transfer_acknowledge_n |->
      ##[1:8] mem_out.chip_select_n)
      else $error("cycle not ended after acknowledge");
   a_burst_count: assert property ($fell(memory_bus_owned) |->
      n_q == (buf_q ? cnt_q : 6'h01))
      else $error("wrong access count per ownership");
   cover property ($fell(memory_bus_owned) && buf_q && cnt_q == MAX_BURST);
   cover property ($fell(memory_bus_owned) && !buf_q);
   cover property (!mem_out.chip_select_n && transfer_acknowledge_n [*6]);
endmodule
`default_nettype wire

// *** bench/smd_mem_model.sv ***
// arbiter and shared static memory on the far side
`timescale 1ns/1ps
`default_nettype none
module smd_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] waits,
   input wire logic memory_bus_request,
   input wire logic memory_bus_owned,
   input wire smd_pkg::smd_mem_out_type mem_out,
   output logic memory_bus_grant,
   output logic transfer_acknowledge_n,
   output logic [smd_pkg::DATA_W-1:0] mem_data_in
);
   import smd_pkg::*;
   logic [DATA_W-1:0] mem_q [256];
   logic [3:0] wait_q;
   // grant held while owned so a released request cannot yank the bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) memory_bus_grant <= 1'b0;
      else memory_bus_grant <= memory_bus_request || (memory_bus_grant && memory_bus_owned);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= '0;
         transfer_acknowledge_n <= 1'b1;
         mem_data_in <= '0;
      end else begin
         wait_q <= mem_out.chip_select_n ? 4'h0 : wait_q + {3'h0, wait_q != 4'hf};
         transfer_acknowledge_n <= mem_out.chip_select_n || wait_q < waits;
         // released bus toggles between the inverse of the last word and the last word itself
         mem_data_in <= !mem_out.read_enable_n ? mem_q[mem_out.addr[7:0]] : ~mem_data_in;
      end
   end
   always_ff @(posedge clk) begin
      if (!mem_out.write_strobe_n && mem_out.data_oe) mem_q[mem_out.addr[7:0]] <= mem_out.data_out;
   end
endmodule
`default_nettype wire

// *** bench/tb_shared_memory_dma_master.sv ***
// self-checking bench for the shared memory dma master
`timescale 1ns/1ps
`default_nettype none
module tb_shared_memory_dma_master;
   import smd_pkg::*;
   typedef struct packed {
      logic wr;
      logic bf;
      logic [5:0] n;
      logic [15:0] a;
      logic [3:0] w;
   } smd_row_type;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] control_word = '0;
   logic job_valid = 1'b0;
   smd_job_type job = '0;
   logic [15:0] core_wdata = '0;
   logic core_wvalid = 1'b0;
   logic [3:0] waits = '0;
   logic job_ready, core_wready, core_rvalid, job_done;
   logic memory_bus_request, memory_bus_grant, memory_bus_owned, transfer_acknowledge_n;
   logic [15:0] core_rdata, mem_data_in;
   smd_mem_out_type mem_out;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   int n_own = 0;
   logic own_d = 1'b0;
   smd_row_type rows [6] = '{
      '{1'b1, 1'b0, 6'h03, 16'h0010, 4'h0},
      '{1'b0, 1'b0, 6'h03, 16'h0010, 4'h5},
      '{1'b1, 1'b1, 6'h20, 16'h0040, 4'h0},
      '{1'b0, 1'b1, 6'h20, 16'h0040, 4'h2},
      '{1'b1, 1'b1, 6'h02, 16'h0080, 4'h5},
      '{1'b0, 1'b1, 6'h02, 16'h0080, 4'h0}};
   smd_dma_master uut (
      .clk(clk),
      .rst_n(rst_n),
      .control_word(control_word),
      .job_valid(job_valid),
      .job(job),
      .job_ready(job_ready),
      .core_wdata(core_wdata),
      .core_wvalid(core_wvalid),
      .core_wready(core_wready),
      .core_rdata(core_rdata),
      .core_rvalid(core_rvalid),
      .job_done(job_done),
      .memory_bus_request(memory_bus_request),
      .memory_bus_grant(memory_bus_grant),
      .memory_bus_owned(memory_bus_owned),
      .transfer_acknowledge_n(transfer_acknowledge_n),
      .mem_data_in(mem_data_in),
      .mem_out(mem_out)
   );
   smd_mem_model mdl (
      .clk(clk),
      .rst_n(rst_n),
      .waits(waits),
      .memory_bus_request(memory_bus_request),
      .memory_bus_owned(memory_bus_owned),
      .mem_out(mem_out),
      .memory_bus_grant(memory_bus_grant),
      .transfer_acknowledge_n(transfer_acknowledge_n),
      .mem_data_in(mem_data_in)
   );
   always #5 clk = ~clk;
   // falling edge: owned is settled here, not racing the edge that launches it
   always @(negedge clk) begin
      own_d <= memory_bus_owned;
      if (memory_bus_owned && !own_d) n_own++;
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         report_and_stop;
      end
   end
   function automatic logic [15:0] pat(input logic [15:0] a);
      return a ^ 16'h5a3c;
   endfunction
   function automatic logic [15:0] pins();
      return {8'h0, mem_out.addr_oe, mem_out.data_oe, mem_out.strobe_oe, mem_out.chip_select_n,
         mem_out.read_enable_n, mem_out.write_strobe_n, memory_bus_request, memory_bus_owned};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic start(input smd_row_type r);
      control_word = {9'h000, r.bf, 6'h00};
      waits = r.w;
      job = '{r.wr, r.a, r.n};
      job_valid = 1'b1;
      n_own = 0;
      while (!job_ready) @(posedge clk) #1;
      @(posedge clk) #1;
      job_valid = 1'b0;
   endtask
   task automatic run(input smd_row_type r);
      int k = 0;
      start(r);
      for (int i = 0; i < r.n && r.wr; i++) begin
         core_wdata = pat(r.a + 16'(i));
         core_wvalid = 1'b1;
         while (!core_wready) @(posedge clk) #1;
         @(posedge clk) #1;
      end
      core_wvalid = 1'b0;
      do begin
         @(posedge clk) #1;
         if (core_rvalid) begin
            check(core_rdata, pat(r.a + 16'(k)));
            k++;
         end
      end while (!job_done);
      check(16'(k), r.wr ? 16'h0 : 16'(r.n));
      check(16'(n_own), r.bf ? 16'h1 : 16'(r.n));
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      check(pins(), 16'h001c);
      @(posedge clk) #1;
      foreach (rows[i]) run(rows[i]);
      // slow memory: access must stay open, then a reset mid-cycle frees the bus
      start('{1'b0, 1'b0, 6'h01, 16'h0010, 4'hf});
      while (mem_out.chip_select_n) @(posedge clk) #1;
      repeat (8) @(posedge clk);
      #1 check(16'(mem_out.chip_select_n), 16'h0);
      rst_n = 1'b0;
      #1 check(pins(), 16'h001c);
      @(posedge clk) #1 rst_n = 1'b1;
      @(posedge clk) #1 check(pins(), 16'h001c);
      @(posedge clk) #1 check(16'(job_ready), 16'h0001);
      report_and_stop;
   end
endmodule
bind smd_dma_master smd_mon mon (
   .clk(clk),
   .rst_n(rst_n),
   .control_word(control_word),
   .job_valid(job_valid),
   .job(job),
   .job_ready(job_ready),
   .memory_bus_grant(memory_bus_grant),
   .memory_bus_owned(memory_bus_owned),
   .transfer_acknowledge_n(transfer_acknowledge_n),
   .mem_out(mem_out)
);
`default_nettype wire
